// File: hw/dynamics_wind_filter.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
module dynamics_wind_filter #(
  parameter int fifo_depth = 32
) (
  // Clock, enable, reset
  input  wire logic        core_clk,
  input  wire logic        clk_en,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Sample input from mixer
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [15:0] in_data,
  // Sample output to converter path
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [15:0] out_data
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {st_idle, st_gain, st_out} phase_type;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] thr;
    logic [15:0] gate_att;
    logic [15:0] gate_rec;
    logic [15:0] wind_ctrl;
    logic [15:0] wind_det;
    logic [15:0] wind_cut;
    logic [15:0] gain;
    logic [15:0] rdata;
    logic [7:0]  vol;
    logic [7:0]  target_vol;
    logic [36:0] timer;
    logic        last_sign;
    logic        wind_on;
    logic signed [31:0] hp_acc;
    logic signed [15:0] hp_prev;
    logic signed [31:0] work;
    phase_type   phase;
    logic [15:0] res;
    logic        res_valid;
  } state_type;

  state_type s;
  state_type next_s;

  // FIFO hand-off
  logic        f_valid;
  logic        f_ready;
  logic [15:0] f_data;

  sample_fifo #(.width(16), .depth(fifo_depth)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // ****************************************
  // Field views
  // ****************************************
  logic        dac_en;
  logic        adc_en;
  logic        gate_mode;
  logic        active;
  logic [4:0]  n_att;
  logic [4:0]  n_rec;
  logic [4:0]  lim_thr;
  logic [4:0]  gate_thr;
  logic [3:0]  reduce;
  logic [7:0]  lim_steps;
  logic [7:0]  gate_steps;
  logic [7:0]  reduce_steps;
  logic [2:0]  rate_sel;
  logic [5:0]  cut_n;
  logic [3:0]  coef_k;
  logic [16:0] coef_a;
  logic [36:0] att_len;
  logic [36:0] rec_len;
  logic [7:0]  level_steps;
  logic        above;
  logic        zero_cross;
  logic [15:0] mag;
  logic [15:0] wind_thr;
  logic        hp_apply;

  assign dac_en    = s.ctrl[dyn_pkg::dac_en_bit];
  assign adc_en    = s.ctrl[dyn_pkg::adc_en_bit];
  assign active    = dac_en || adc_en;
  assign gate_mode = s.ctrl[dyn_pkg::gate_mode_bit];
  // In gate mode the timers come from the extended parameters
  assign n_att = gate_mode ? s.gate_att[dyn_pkg::rec_lsb +: 5]
                           : s.ctrl[dyn_pkg::att_lsb +: 5];
  assign n_rec = gate_mode ? s.gate_rec[dyn_pkg::att_lsb +: 5]
                           : s.ctrl[dyn_pkg::rec_lsb +: 5];
  assign lim_thr  = s.thr[dyn_pkg::lim_lsb +: 5];
  assign gate_thr = s.thr[dyn_pkg::gate_thr_lsb +: 5];
  assign reduce   = s.thr[dyn_pkg::reduce_lsb +: 4];
  // Thresholds as attenuation in 0.375 dB steps below full scale
  assign lim_steps    = 8'(lim_thr * dyn_pkg::steps_per_thr);
  assign gate_steps   = 8'(dyn_pkg::gate_base_steps
                         + gate_thr * dyn_pkg::steps_per_thr);
  assign reduce_steps = 8'(reduce * dyn_pkg::steps_per_reduce);
  // Four times two to the n sample periods
  assign att_len = 37'(37'h1 << (n_att + dyn_pkg::rate_base_shift));
  assign rec_len = 37'(37'h1 << (n_rec + dyn_pkg::rate_base_shift));

  // Level: steps of 0.375 dB below full scale, coarse log via MSB
  assign mag = f_data[15] ? 16'(~f_data) : f_data;
  always_comb begin
    level_steps = vol_max_att_f();
    for (int i = 0; i < 15; i++) begin
      if (mag[i]) level_steps = 8'((14 - i) * 16);
    end
  end
  function automatic logic [7:0] vol_max_att_f();
    return dyn_pkg::vol_max_att;
  endfunction : vol_max_att_f

  assign above = gate_mode ? (level_steps < gate_steps)
                           : (level_steps < lim_steps);
  assign zero_cross = f_valid && (f_data[15] != s.last_sign);

  // Wind filter coefficient group by rate selection
  assign rate_sel = s.wind_ctrl[dyn_pkg::rate_lsb +: 3];
  always_comb begin
    case (rate_sel)
      3'h0:    coef_k = dyn_pkg::coef_shift_lo;
      3'h1:    coef_k = 4'(dyn_pkg::coef_shift_lo + 1);
      3'h2:    coef_k = 4'(dyn_pkg::coef_shift_lo + 2);
      3'h3:    coef_k = 4'(dyn_pkg::coef_shift_lo + 3);
      default: coef_k = 4'(dyn_pkg::coef_shift_lo + 4);
    endcase
  end
  assign cut_n  = s.wind_cut[dyn_pkg::cut_lsb +: 6];
  // a = (n+1) * 2^-k in Q16; top index at rate selection 0 gives a = 1.0, so 17 bits
  assign coef_a = 17'((17'(cut_n) + 17'h1) << (16 - coef_k));
  assign wind_thr = s.wind_det[15:0] & 16'h7FFF;
  // Detection off: filter follows its enable alone (DC removal)
  assign hp_apply = s.wind_ctrl[dyn_pkg::wind_en_bit] &&
                    (!s.wind_det[dyn_pkg::det_en_bit] || s.wind_on);

  assign f_ready   = (s.phase == st_idle) && !s.res_valid;
  assign out_valid = s.res_valid;
  assign out_data  = s.res;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic signed [15:0] x;
    logic signed [31:0] hp;
    logic [7:0]         pre;
    logic [7:0]         post;
    x    = signed'(f_data);
    hp   = '0;
    pre  = s.gain[dyn_pkg::pre_lsb +: 8];
    post = s.gain[dyn_pkg::post_lsb +: 8];
    next_s = s;
    next_s.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        dyn_pkg::dyn_ctrl_addr:  next_s.ctrl      = reg_wdata;
        dyn_pkg::dyn_thr_addr:   next_s.thr       = reg_wdata;
        dyn_pkg::gate_att_addr:  next_s.gate_att  = reg_wdata;
        dyn_pkg::gate_rec_addr:  next_s.gate_rec  = reg_wdata;
        dyn_pkg::wind_ctrl_addr: next_s.wind_ctrl = reg_wdata;
        dyn_pkg::wind_det_addr:  next_s.wind_det  = reg_wdata;
        dyn_pkg::wind_cut_addr:  next_s.wind_cut  = reg_wdata;
        dyn_pkg::gain_addr:      next_s.gain      = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        dyn_pkg::dyn_ctrl_addr:  next_s.rdata = s.ctrl;
        dyn_pkg::dyn_thr_addr:   next_s.rdata = s.thr;
        dyn_pkg::gate_att_addr:  next_s.rdata = s.gate_att;
        dyn_pkg::gate_rec_addr:  next_s.rdata = s.gate_rec;
        dyn_pkg::wind_ctrl_addr: next_s.rdata = s.wind_ctrl;
        dyn_pkg::wind_det_addr:  next_s.rdata = s.wind_det;
        dyn_pkg::wind_cut_addr:  next_s.rdata = s.wind_cut;
        dyn_pkg::gain_addr:      next_s.rdata = s.gain;
        dyn_pkg::status_addr:    next_s.rdata = {s.wind_on, 7'h00, s.vol};
        default:                 next_s.rdata = '0;
      endcase
    end
    if (s.res_valid && out_ready) next_s.res_valid = 1'b0;
    // Pacing timer counts samples between volume steps
    if (f_valid && f_ready && s.timer != '0)
      next_s.timer = 37'(s.timer - 1'b1);
    // Gate target: reduce quiet input, back to unity when loud
    if (gate_mode)
      next_s.target_vol = above ? 8'h00 : reduce_steps;
    else
      next_s.target_vol = above ? 8'(level_steps > lim_steps ? 0
                          : lim_steps - level_steps) : 8'h00;
    case (s.phase)
      st_idle: begin
        // Take a sample only when it pops, or it would be processed twice
        if (f_valid && f_ready) begin
          next_s.last_sign = f_data[15];
          // Pre-gain enlarges first, shifts in 6 dB units
          next_s.work  = 32'(signed'(x) <<< pre[2:0]);
          // Wind energy detector on raw input magnitude
          if (s.wind_det[dyn_pkg::det_en_bit])
            next_s.wind_on = (mag > wind_thr);
          if (hp_apply) begin
            // One-pole high-pass: y = x - lp, lp += a*(x - lp)
            hp = 32'(x) - (s.hp_acc >>> 16);
            next_s.hp_acc = 32'(s.hp_acc + 32'(hp * signed'({1'b0, coef_a})));
            next_s.work = 32'(hp <<< pre[2:0]);
          end
          next_s.hp_prev = x;
          if (active && zero_cross && s.timer == '0) begin
            if (s.vol < s.target_vol) begin
              next_s.vol   = 8'(s.vol + 1'b1);
              next_s.timer = att_len;
            end else if (s.vol > s.target_vol) begin
              next_s.vol   = 8'(s.vol - 1'b1);
              next_s.timer = rec_len;
            end
          end
          next_s.phase = st_gain;
        end
      end
      st_gain: begin
        // Volume stage attenuates; 16 steps is 6 dB
        if (active)
          next_s.work = s.work >>> s.vol[7:4];
        next_s.phase = st_out;
      end
      st_out: begin
        if (!s.res_valid || out_ready) begin
          // Post-gain fine tune, saturated to 16 bits
          hp = s.work + ((s.work * signed'(32'(post))) >>> 8);
          if (hp > 32'sh7FFF)       next_s.res = 16'h7FFF;
          else if (hp < -32'sh8000) next_s.res = 16'h8000;
          else                      next_s.res = hp[15:0];
          next_s.res_valid = 1'b1;
          next_s.phase     = st_idle;
        end
      end
      default: next_s.phase = st_idle;
    endcase
  end

  assign reg_rdata = s.rdata;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s           <= '0;
      s.ctrl      <= dyn_pkg::ctrl_reset;
      s.thr       <= dyn_pkg::thr_reset;
      s.gain      <= dyn_pkg::gain_reset;
      s.wind_det  <= dyn_pkg::wind_det_reset;
      s.phase     <= st_idle;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  vol_step_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> (s.vol == $past(s.vol) || s.vol == 8'($past(s.vol) + 1)
                || s.vol == 8'($past(s.vol) - 1)))
    else $error("volume moved more than one step");
  vol_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !active) |=> s.vol == $past(s.vol))
    else $error("volume changed while disabled");
  att_time_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && s.vol > $past(s.vol)) |-> s.timer == att_len)
    else $error("attack timer not loaded");
  rec_time_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && s.vol < $past(s.vol)) |-> s.timer == rec_len)
    else $error("recovery timer not loaded");
  vol_bound_a: assert property (@(posedge core_clk) disable iff (rst)
    (gate_mode && s.vol > reduce_steps && !$changed(s.thr)
     && s.timer == '0 && clk_en) |=> s.vol <= $past(s.vol))
    else $error("gate volume above reduction");
  stage_seq_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && s.phase == st_gain) |=> s.phase == st_out)
    else $error("gain stage order broken");
  lim_scale_a: assert property (@(posedge core_clk) disable iff (rst)
    lim_steps == 8'(lim_thr) * 8'h04)
    else $error("limit threshold scale");
  gate_scale_a: assert property (@(posedge core_clk) disable iff (rst)
    gate_steps == 8'h60 + 8'(gate_thr) * 8'h04)
    else $error("gate threshold scale");
endmodule : dynamics_wind_filter

// File: hw/dyn_pkg.sv
package dyn_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] dyn_ctrl_addr   = 4'h0;
  localparam logic [3:0] dyn_thr_addr    = 4'h1;
  localparam logic [3:0] gate_att_addr   = 4'h2;
  localparam logic [3:0] gate_rec_addr   = 4'h3;
  localparam logic [3:0] wind_ctrl_addr  = 4'h4;
  localparam logic [3:0] wind_det_addr   = 4'h5;
  localparam logic [3:0] wind_cut_addr   = 4'h6;
  localparam logic [3:0] gain_addr       = 4'h7;
  localparam logic [3:0] status_addr     = 4'h8;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int dac_en_bit   = 15;
  localparam int adc_en_bit   = 14;
  localparam int gate_mode_bit = 13;
  localparam int att_lsb      = 8;
  localparam int rec_lsb      = 0;
  localparam int lim_lsb      = 7;
  localparam int gate_thr_lsb = 0;
  localparam int reduce_lsb   = 12;
  localparam int wind_en_bit  = 15;
  localparam int rate_lsb     = 12;
  localparam int det_en_bit   = 15;
  localparam int cut_lsb      = 6;
  localparam int post_lsb     = 8;
  localparam int pre_lsb      = 0;
  // ****************************************
  // Reset values and gain constants
  // ****************************************
  localparam logic [15:0] ctrl_reset   = 16'h0000;
  localparam logic [15:0] thr_reset    = 16'h0000;
  localparam logic [15:0] gain_reset   = 16'h0000;
  localparam logic [15:0] wind_det_reset = 16'h0400;
  // Volume in 0.375 dB steps; 1.5 dB = 4 steps, 3 dB = 8 steps
  localparam logic [7:0] steps_per_thr    = 8'h04;
  localparam logic [7:0] steps_per_reduce = 8'h08;
  localparam logic [7:0] gate_base_steps  = 8'h60;
  localparam logic [7:0] vol_max_att      = 8'hFF;
  localparam logic [4:0] rate_base_shift  = 5'h02;
  localparam logic [3:0] coef_shift_lo    = 4'h6;
endpackage : dyn_pkg

// File: hw/sample_fifo.sv
module sample_fifo #(
  parameter int width = 16,
  parameter int depth = 32
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [width-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [width-1:0] out_data
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0]      wr_ptr;
  logic [aw:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             pop;

  assign full      = (wr_ptr[aw] != rd_ptr[aw]) &&
                     (wr_ptr[aw-1:0] == rd_ptr[aw-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  // Read data come from a register, so a valid flag follows it
  assign pop       = !empty && (!out_valid || out_ready);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (clk_en) begin
      if (in_valid && !full) begin
        mem[wr_ptr[aw-1:0]] <= in_data;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data  <= mem[rd_ptr[aw-1:0]];
        rd_ptr    <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : sample_fifo

// File: bench/mixer_path_model.sv
module mixer_path_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Toward the block input
  output logic             in_valid,
  input  wire logic        in_ready,
  output logic      [15:0] in_data,
  // From the block output
  input  wire logic        out_valid,
  output logic             out_ready,
  input  wire logic [15:0] out_data,
  // Bench control
  input  wire logic        stall
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] last_out;
  int          out_count;

  initial begin
    in_valid = 1'b0;
    in_data  = 16'h0000;
  end

  // The converter side may stall to back the samples up
  always_comb out_ready = !stall;

  always @(posedge core_clk) begin
    if (rst) begin
      out_count <= 0;
    end else if (out_valid && out_ready) begin
      out_count <= out_count + 1;
      last_out  <= out_data;
    end
  end

  // Hold the sample until taken or 64 cycles pass; a released line shows the inverse
  task automatic send(input logic [15:0] data, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge core_clk);
    in_valid <= 1'b1;
    in_data  <= data;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge core_clk);
      if (in_ready === 1'b1) ok = 1'b1;
    end
    in_valid <= 1'b0;
    in_data  <= ~data;
  endtask : send
endmodule : mixer_path_model

// File: bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        in_valid;
  logic        in_ready;
  logic [15:0] in_data;
  logic        out_valid;
  logic        out_ready;
  logic [15:0] out_data;
  logic        stall;
  logic        clk_en;
  int          miscompares;
  int          checks_done;
  int          cycles;
  int          sent;

  dynamics_wind_filter #(.fifo_depth(32)) dynamics_wind_filter_i (
    .core_clk(core_clk), .clk_en(clk_en), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
  );

  mixer_path_model mixer_path_model_i (
    .core_clk(core_clk), .rst(rst),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .stall(stall)
  );

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // Whole run needs roughly 11000 cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : reg_read

  // Sends n samples, alternating in sign when alt, then waits for drain
  task automatic run(input int n, input logic [15:0] amp, input bit alt);
    logic ok;
    int   w;
    for (int i = 0; i < n; i++) begin
      mixer_path_model_i.send((alt && i[0]) ? -amp : amp, ok);
      if (ok) sent++;
    end
    for (w = 0; w < 400 && mixer_path_model_i.out_count != sent; w++)
      @(posedge core_clk);
    check(16'(mixer_path_model_i.out_count), 16'(sent));
  endtask : run

  task automatic finish_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // Main sequence
  // ****************************************
  logic [3:0]  ra [8] = '{dyn_pkg::dyn_ctrl_addr, dyn_pkg::dyn_thr_addr,
    dyn_pkg::gate_att_addr, dyn_pkg::gate_rec_addr, dyn_pkg::wind_ctrl_addr,
    dyn_pkg::wind_det_addr, dyn_pkg::wind_cut_addr, dyn_pkg::gain_addr};
  logic [15:0] rv [8] = '{16'hA513, 16'h5A85, 16'h0015, 16'h1300,
    16'h3000, 16'h0123, 16'h0A40, 16'h4003};
  logic [15:0] rm [8] = '{16'hFF1F, 16'hFF9F, 16'h001F, 16'h1F00,
    16'hF000, 16'hFFFF, 16'h0FC0, 16'hFF07};

  initial begin
    logic [15:0] d;
    logic        ok;
    int          acc;
    rst = 1'b1; reg_addr = 4'h0; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; stall = 1'b0; clk_en = 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    reg_read(dyn_pkg::dyn_ctrl_addr, d);
    check(d, dyn_pkg::ctrl_reset);
    reg_read(dyn_pkg::dyn_thr_addr, d);
    check(d, dyn_pkg::thr_reset);
    reg_read(dyn_pkg::wind_det_addr, d);
    check(d, dyn_pkg::wind_det_reset);
    for (int i = 0; i < 8; i++) begin
      reg_write(ra[i], rv[i]);
      reg_read(ra[i], d);
      check(d & rm[i], rv[i]);
    end
    reg_write(4'hF, 16'hFFFF);
    reg_read(4'hF, d);
    check(d, 16'h0000);
    reg_write(dyn_pkg::status_addr, 16'hFFFF);
    for (int i = 0; i < 8; i++) reg_write(ra[i], 16'h0000);
    // With the enable low a write must not land
    clk_en <= 1'b0;
    reg_write(dyn_pkg::gain_addr, 16'h1234);
    clk_en <= 1'b1;
    reg_read(dyn_pkg::gain_addr, d);
    check(d, 16'h0000);
    reg_read(dyn_pkg::status_addr, d);
    check(d, 16'h0000);

    // Converter stalls: the buffer must refuse, then drain completely
    stall <= 1'b1;
    acc = 0;
    for (int i = 0; i < 40; i++) begin
      mixer_path_model_i.send(16'(i), ok);
      if (ok) acc++;
    end
    check({15'h0000, acc >= 32 && acc <= 36}, 16'h0001);
    check({15'h0000, in_ready}, 16'h0000);
    sent = acc;
    stall <= 1'b0;
    run(0, 16'h0000, 1'b0);

    // Playback then recording path: attack and recovery rates
    reg_write(dyn_pkg::dyn_thr_addr, 16'h0F80);
    for (int b = 0; b < 2; b++) begin
      d = b ? 16'h4000 : 16'h8000;
      reg_write(dyn_pkg::dyn_ctrl_addr, d | 16'h001F);
      run(60, 16'h7000, 1'b1);
      reg_read(dyn_pkg::status_addr, d);
      check({15'h0000, d[7:0] >= 8'h08}, 16'h0001);
      reg_write(dyn_pkg::dyn_ctrl_addr, b ? 16'h4000 : 16'h8000);
      run(200, 16'h0004, 1'b1);
      reg_read(dyn_pkg::status_addr, d);
      check(d, 16'h0000);
      reg_write(dyn_pkg::dyn_ctrl_addr, b ? 16'h451F : 16'h851F);
      run(60, 16'h7000, 1'b1);
      reg_read(dyn_pkg::status_addr, d);
      check({15'h0000, d[7:0] <= 8'h01}, 16'h0001);
      reg_write(dyn_pkg::dyn_ctrl_addr, 16'h0000);
      run(200, 16'h0004, 1'b1);
    end

    // Noise gate: 45 dB cut below the gate, restored above it
    reg_write(dyn_pkg::dyn_thr_addr, 16'hF000);
    reg_write(dyn_pkg::dyn_ctrl_addr, 16'hA01F);
    run(640, 16'h0004, 1'b1);
    reg_read(dyn_pkg::status_addr, d);
    check(d, 16'h0078);
    run(600, 16'h0800, 1'b1);
    reg_read(dyn_pkg::status_addr, d);
    check(d, 16'h0000);
    reg_write(dyn_pkg::dyn_ctrl_addr, 16'h0000);

    // Wind filter set up in the prescribed order
    reg_write(dyn_pkg::wind_det_addr, 16'h0400);
    reg_write(dyn_pkg::wind_ctrl_addr, 16'h0000);
    reg_write(dyn_pkg::wind_cut_addr, 16'h0FC0);
    reg_write(dyn_pkg::wind_ctrl_addr, 16'h8000);
    reg_write(dyn_pkg::wind_det_addr, 16'h8400);
    run(50, 16'h7000, 1'b1);
    reg_read(dyn_pkg::status_addr, d);
    check({15'h0000, d[15]}, 16'h0001);
    run(50, 16'h0004, 1'b1);
    reg_read(dyn_pkg::status_addr, d);
    check({15'h0000, d[15]}, 16'h0000);
    reg_write(dyn_pkg::wind_det_addr, 16'h0400);
    run(200, 16'h1000, 1'b0);
    d = mixer_path_model_i.last_out;
    d = d[15] ? -d : d;
    check({15'h0000, d < 16'h0100}, 16'h0001);
    finish_test();
  end
endmodule : tb_top
